// ### hw/flash_pkg.sv
// shared constants, types and helpers for the serial flash command block
package flash_pkg;
  localparam int          CLK_PERIOD_NS       = 5;
  localparam int          PAGE_BYTES          = 256;
  localparam logic [7:0]  WRITE_ENABLE_CMD    = 8'h06;
  localparam logic [7:0]  WRITE_DISABLE_CMD   = 8'h04;
  localparam logic [7:0]  STATUS_READ_CMD     = 8'h05;
  localparam logic [7:0]  STATUS_WRITE_CMD    = 8'h01;
  localparam logic [7:0]  PAGE_PROGRAM_CMD    = 8'h02;
  localparam logic [7:0]  SECTOR_ERASE_CMD    = 8'hD8;
  localparam logic [7:0]  ARRAY_ERASE_CMD     = 8'hC7;
  localparam logic [7:0]  DEEP_SLEEP_CMD      = 8'hB9;
  localparam logic [7:0]  WAKE_AND_ID_CMD     = 8'hAB;
  localparam logic [15:0] BITS_OPCODE         = 16'h0008;
  localparam logic [15:0] BITS_STATUS_WRITE   = 16'h0010;
  localparam logic [15:0] BITS_ADDR_CMD       = 16'h0020;
  localparam logic [15:0] BITS_PROGRAM_MIN    = 16'h0028;
  localparam logic [15:0] BIT_COUNT_MAX       = 16'hFFFF;
  localparam logic [12:0] FIRST_DATA_BYTE     = 13'h0004;
  localparam int          BUSY_POS            = 0;
  localparam int          WEL_POS             = 1;
  localparam int          BP_LSB              = 2;
  localparam int          SRP_POS             = 7;
  localparam logic [23:0] PROT_HALF           = 24'h080000;
  localparam logic [23:0] PROT_QUARTER        = 24'h0C0000;
  localparam logic [23:0] PROT_EIGHTH         = 24'h0E0000;
  localparam logic [23:0] PROT_SIXTEENTH      = 24'h0F0000;
  localparam logic [2:0]  SYNC_RST            = 3'h5;
  localparam logic [7:0]  STATUS_RST          = 8'h00;

  typedef enum {ST_IDLE, ST_PROG_RD, ST_PROG_WR, ST_WAIT} core_state_e;

  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
    logic        erase_sector;
    logic        erase_all;
  } mem_req_s;

  typedef struct packed {
    logic       status_protect_bit;
    logic [2:0] bp;
  } nv_bits_s;

  localparam nv_bits_s NV_RST = '{status_protect_bit: 1'b0, bp: 3'h0};

  function automatic logic prot_hit(input logic [2:0] bp, input logic [23:0] a);
    logic [23:0] pa;
    pa = {4'h0, a[19:0]};
    case (bp)
      3'h0:    prot_hit = 1'b0;
      3'h1:    prot_hit = pa >= PROT_SIXTEENTH;
      3'h2:    prot_hit = pa >= PROT_EIGHTH;
      3'h3:    prot_hit = pa >= PROT_QUARTER;
      3'h4:    prot_hit = pa >= PROT_HALF;
      default: prot_hit = 1'b1;
    endcase
  endfunction : prot_hit
endpackage : flash_pkg

// ### hw/serial_flash_protect_power_hold.sv
// serial flash command sequencer: link front end, protection, busy timing, power states
`timescale 1ns/1ps
module serial_flash_protect_power_hold #(
  parameter int PROGRAM_TIME_US      = 1000,
  parameter int SECTOR_ERASE_TIME_US = 100000,
  parameter int ARRAY_ERASE_TIME_US  = 1000000,
  parameter int STATUS_WRITE_TIME_US = 1000,
  parameter int POWERUP_DELAY_US     = 1000
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               serial_in,
  input  wire logic               hold_n,
  input  wire logic               wp_n,
  output logic                    serial_out,
  output logic                    serial_out_en,
  output flash_pkg::mem_req_s     mem_req,
  input  wire logic [7:0]         mem_rdata,
  input  wire flash_pkg::nv_bits_s nv_init,
  output flash_pkg::nv_bits_s     nv_store,
  output logic                    deep_sleep,
  output logic                    active_power
);
  import flash_pkg::*;

  localparam logic [31:0] PROG_CYC  = 32'((longint'(PROGRAM_TIME_US) * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] SE_CYC    = 32'((longint'(SECTOR_ERASE_TIME_US) * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] BE_CYC    = 32'((longint'(ARRAY_ERASE_TIME_US) * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] STATUS_WRITE_CMD_CYC  = 32'((longint'(STATUS_WRITE_TIME_US) * 1000) / CLK_PERIOD_NS);
  localparam logic [31:0] PU_CYC    = 32'((longint'(POWERUP_DELAY_US) * 1000) / CLK_PERIOD_NS);

  // ---- link side, clocked by sclk ----
  logic        spi_clr;
  logic        first;
  logic [15:0] cnt;
  logic [15:0] base;
  logic [7:0]  sh;
  logic [7:0]  byte_in;
  logic [7:0]  op;
  logic [23:0] addr;
  logic        frame_tgl;
  logic        hold_q;
  logic        pause;
  logic        byte_done;
  logic        data_byte;
  logic [7:0]  wr_idx;
  logic [7:0]  page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask;
  logic [8:0]  ss1;
  logic [8:0]  ss2;
  logic [8:0]  ss3;
  logic [8:0]  view;
  logic        out_en_q;
  logic [7:0]  status_q;

  // deselect or power reset sets the frame start flag and clears the output stage; the raw pin is only a reset here
  assign spi_clr   = cs_n | ~rst_n;
  assign base      = first ? 16'h0000 : cnt;
  assign byte_in   = {sh[6:0], serial_in};
  assign byte_done = hold_n && (base[2:0] == 3'h7);
  assign data_byte = byte_done && (base[15:3] >= FIRST_DATA_BYTE) && (op == PAGE_PROGRAM_CMD) && !view[BUSY_POS];
  assign wr_idx    = 8'(addr[7:0] + base[10:3] - 8'h04);

  always_ff @(posedge sclk or posedge spi_clr) begin
    if (spi_clr) begin
      first <= 1'b1;
    end else if (hold_n) begin
      first <= 1'b0;
    end
  end

  // count survives deselect so the core can judge the finished frame
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= 16'h0000;
      sh        <= 8'h00;
      frame_tgl <= 1'b0;
    // a clock edge while deselected, as on a switch of idle level, must not start a frame
    end else if (hold_n && !cs_n) begin
      frame_tgl <= frame_tgl ^ first;
      sh        <= byte_in;
      if (base != BIT_COUNT_MAX) begin
        cnt <= base + 16'h0001;
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      op   <= 8'h00;
      addr <= 24'h000000;
    end else if (byte_done) begin
      case (base[15:3])
        13'h0000: op <= byte_in;
        13'h0001: addr[23:16] <= byte_in;
        13'h0002: addr[15:8] <= byte_in;
        13'h0003: addr[7:0] <= byte_in;
        default: ;
      endcase
    end
  end

  // buffer is frozen while busy so a new frame cannot disturb the walk
  always_ff @(posedge sclk) begin
    if (data_byte) begin
      page_buf[wr_idx] <= byte_in;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      page_mask <= '0;
    end else if (data_byte) begin
      if (base[15:3] == FIRST_DATA_BYTE) begin
        page_mask <= PAGE_BYTES'(1) << wr_idx;
      end else begin
        page_mask[wr_idx] <= 1'b1;
      end
    end
  end

  // status crosses bit by bit; each bit is meaningful on its own
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      ss1  <= 9'h000;
      ss2  <= 9'h000;
      ss3  <= 9'h000;
      view <= 9'h000;
    end else begin
      ss1  <= {deep_sleep, status_q};
      ss2  <= ss1;
      ss3  <= ss2;
      view <= (ss2 & ~(ss2 ^ ss3)) | (view & (ss2 ^ ss3));
    end
  end

  // pause follows the pin while sclk is low and holds while it is high
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= ~hold_n;
    end
  end
  assign pause = sclk ? hold_q : ~hold_n;

  always_ff @(negedge sclk or posedge spi_clr) begin
    if (spi_clr) begin
      out_en_q   <= 1'b0;
      serial_out <= 1'b0;
    end else if (hold_n) begin
      if (!first && cnt >= BITS_OPCODE && op == STATUS_READ_CMD && !view[8]) begin
        out_en_q   <= 1'b1;
        serial_out <= view[3'h7 - cnt[2:0]];
      end
    end
  end
  // gated live so the output floats the moment a pause begins
  assign serial_out_en = out_en_q & ~pause;

  // ---- core side, clocked by ref_clk ----
  logic [2:0]  s1;
  logic [2:0]  s2;
  logic [2:0]  s3;
  logic [2:0]  stable;
  logic        cs_prev;
  logic        frame_seen;
  logic        take;
  logic        busy;
  logic        write_enable_latch;
  logic        sleep;
  logic        hw_lock;
  logic        pu_done;
  logic [31:0] pu_cnt;
  logic [31:0] timer;
  logic        nv_loaded;
  nv_bits_s    nv;
  logic [7:0]  idx;
  logic [23:0] cmd_addr;
  core_state_e state;
  logic        mod_ok;
  logic        ok_write_enable_cmd;
  logic        ok_write_disable_cmd;
  logic        ok_dp;
  logic        ok_wake;
  logic        ok_status_write_cmd;
  logic        ok_pp;
  logic        ok_se;
  logic        ok_be;
  logic        cycle_done;

  // {cs_n, frame toggle, wp_n}: three stages, taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1     <= SYNC_RST;
      s2     <= SYNC_RST;
      s3     <= SYNC_RST;
      stable <= SYNC_RST;
    end else begin
      s1     <= {cs_n, frame_tgl, wp_n};
      s2     <= s1;
      s3     <= s2;
      stable <= (s2 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev    <= 1'b1;
      frame_seen <= 1'b0;
    end else begin
      cs_prev <= stable[2];
      if (take) begin
        frame_seen <= stable[1];
      end
    end
  end

  // frame fields are quiet once select is high, so they are read directly
  assign take       = stable[2] && !cs_prev && (stable[1] != frame_seen);
  assign busy       = (state != ST_IDLE);
  assign hw_lock    = nv.status_protect_bit && !stable[0];
  assign pu_done    = (pu_cnt == 32'h0);
  assign mod_ok     = pu_done && !busy && !sleep && write_enable_latch;
  assign ok_write_enable_cmd    = (op == WRITE_ENABLE_CMD) && (cnt == BITS_OPCODE) && !busy && !sleep;
  assign ok_write_disable_cmd    = (op == WRITE_DISABLE_CMD) && (cnt == BITS_OPCODE) && !busy && !sleep;
  assign ok_dp      = (op == DEEP_SLEEP_CMD) && (cnt == BITS_OPCODE) && !busy && !sleep;
  assign ok_wake    = (op == WAKE_AND_ID_CMD) && (cnt >= BITS_OPCODE) && sleep;
  assign ok_status_write_cmd    = (op == STATUS_WRITE_CMD) && (cnt == BITS_STATUS_WRITE) && mod_ok && !hw_lock;
  assign ok_pp      = (op == PAGE_PROGRAM_CMD) && (cnt >= BITS_PROGRAM_MIN) && (cnt[2:0] == 3'h0)
                      && mod_ok && !prot_hit(nv.bp, addr);
  assign ok_se      = (op == SECTOR_ERASE_CMD) && (cnt == BITS_ADDR_CMD) && mod_ok && !prot_hit(nv.bp, addr);
  assign ok_be      = (op == ARRAY_ERASE_CMD) && (cnt == BITS_OPCODE) && mod_ok && (nv.bp == 3'h0);
  assign cycle_done = (state == ST_WAIT) && (timer == 32'h0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt <= PU_CYC;
    end else if (!pu_done) begin
      pu_cnt <= pu_cnt - 32'h1;
    end
  end

  // protect bits come from the external store after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv        <= NV_RST;
      nv_loaded <= 1'b0;
    end else if (!nv_loaded) begin
      nv        <= nv_init;
      nv_loaded <= 1'b1;
    end else if (take && ok_status_write_cmd) begin
      nv.status_protect_bit <= addr[16 + SRP_POS];
      nv.bp  <= addr[16 + BP_LSB +: 3];
    end
  end
  assign nv_store = nv;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
    end else if (take && ok_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if ((take && ok_write_disable_cmd) || cycle_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep <= 1'b0;
    end else if (take && ok_dp) begin
      sleep <= 1'b1;
    end else if (take && ok_wake) begin
      sleep <= 1'b0;
    end
  end
  assign deep_sleep = sleep;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= 32'h0;
    end else if (take && ok_pp) begin
      timer <= PROG_CYC;
    end else if (take && ok_se) begin
      timer <= SE_CYC;
    end else if (take && ok_be) begin
      timer <= BE_CYC;
    end else if (take && ok_status_write_cmd) begin
      timer <= STATUS_WRITE_CMD_CYC;
    end else if (timer != 32'h0) begin
      timer <= timer - 32'h1;
    end
  end

  // read-modify-write per marked byte; array answers while rd is high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      idx      <= 8'h00;
      cmd_addr <= 24'h000000;
      mem_req  <= '0;
    end else begin
      mem_req <= '0;
      case (state)
        ST_IDLE: begin
          idx      <= 8'h00;
          cmd_addr <= addr;
          if (take && ok_pp) begin
            state <= ST_PROG_RD;
          end else if (take && (ok_se || ok_be)) begin
            state                <= ST_WAIT;
            mem_req.addr         <= addr[19:0];
            mem_req.erase_sector <= ok_se;
            mem_req.erase_all    <= ok_be;
          end else if (take && ok_status_write_cmd) begin
            state <= ST_WAIT;
          end
        end
        ST_PROG_RD: begin
          if (page_mask[idx]) begin
            mem_req.rd   <= 1'b1;
            mem_req.addr <= {cmd_addr[19:8], idx};
            state        <= ST_PROG_WR;
          end else begin
            idx   <= idx + 8'h01;
            state <= (idx == 8'hFF) ? ST_WAIT : ST_PROG_RD;
          end
        end
        ST_PROG_WR: begin
          mem_req.wr    <= 1'b1;
          mem_req.addr  <= {cmd_addr[19:8], idx};
          mem_req.wdata <= mem_rdata & page_buf[idx];
          idx           <= idx + 8'h01;
          state         <= (idx == 8'hFF) ? ST_WAIT : ST_PROG_RD;
        end
        ST_WAIT: begin
          if (timer == 32'h0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q     <= STATUS_RST;
      active_power <= 1'b0;
    end else begin
      status_q               <= STATUS_RST;
      status_q[BUSY_POS]     <= busy;
      status_q[WEL_POS]      <= write_enable_latch;
      status_q[BP_LSB +: 3]  <= nv.bp;
      status_q[SRP_POS]      <= nv.status_protect_bit;
      active_power           <= !stable[2] || busy;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_start;
    (state == ST_IDLE) ##1 (state != ST_IDLE);
  endsequence
  sequence seq_done;
    (state == ST_WAIT) && (timer == 32'h0);
  endsequence

  a_wel_before_cycle: assert property (seq_start |-> $past(write_enable_latch)) else $error("cycle began without latch");
  a_busy_shown: assert property (seq_start |=> status_q[BUSY_POS]) else $error("busy not shown");
  a_wel_after_done: assert property (seq_done |=> !write_enable_latch && state == ST_IDLE) else $error("latch kept");
  a_byte_count: assert property (seq_start |-> $past(cnt[2:0]) == 3'h0) else $error("partial byte taken");
  a_prot_region: assert property ((state == ST_IDLE) ##1 (state == ST_PROG_RD) |-> !prot_hit(nv.bp, cmd_addr))
    else $error("protected page programmed");
  a_clear_only: assert property (mem_req.wr |-> (mem_req.wdata & ~$past(mem_rdata)) == 8'h00)
    else $error("program set a bit");
  a_sleep_inert: assert property (sleep && !write_enable_latch && state == ST_IDLE |=> !write_enable_latch && state == ST_IDLE)
    else $error("command ran asleep");
  a_wake_cause: assert property ($fell(sleep) |-> $past(take && op == WAKE_AND_ID_CMD))
    else $error("woke without command");
  a_powerup_block: assert property (!pu_done |-> state == ST_IDLE && timer == 32'h0)
    else $error("change before timer");
  a_hw_lock: assert property (nv_loaded && hw_lock |=> $stable(nv)) else $error("locked bits changed");
  a_pause_freeze: assert property (@(posedge sclk) disable iff (spi_clr) !hold_n |=> $stable(cnt))
    else $error("count moved in pause");
endmodule : serial_flash_protect_power_hold

// ### verification/host_link_model.sv
// host side link model: drives select, clock, data and pause
`timescale 1ns/1ps
module host_link_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  output logic      hold_n,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  logic [7:0] tx_buf [0:259];
  logic [7:0] rx;
  logic       en_in_hold;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    hold_n = 1'b1;
    rx = 8'h00;
    en_in_hold = 1'b0;
  end
  // clock stands still between frames; idle level picks mode 0 or 3
  task automatic frame(input int bits, input logic m3, input int hold_at);
    int i;
    sclk = m3;
    #20;
    cs_n = 1'b0;
    for (i = 0; i < bits; i++) begin
      sclk = 1'b0;
      if (i == hold_at) begin
        hold_n = 1'b0;
        #20;
        repeat (4) begin
          sclk = ~sclk;
          serial_in = ~serial_in;
          #31;
          en_in_hold = en_in_hold | serial_out_en;
        end
        hold_n = 1'b1;
        #20;
      end
      serial_in = tx_buf[i / 8][7 - i % 8];
      #62.5;
      sclk = 1'b1;
      // a floating output reads as the pull-up level
      rx = {rx[6:0], serial_out_en ? serial_out : 1'b1};
      #62.5;
    end
    sclk = m3;
    #62.5;
    cs_n = 1'b1;
    // a released line must not look like the last bit
    serial_in = ~serial_in;
    #150;
  endtask : frame
endmodule : host_link_model

// ### verification/serial_flash_protect_power_hold_bench.sv
// self-checking bench for the serial flash command sequencer
`timescale 1ns/1ps
module serial_flash_protect_power_hold_bench;
  import flash_pkg::*;
  logic       ref_clk;
  logic       rst_n;
  logic       wp_n;
  wire        sclk;
  wire        cs_n;
  wire        serial_in;
  wire        hold_n;
  wire        serial_out;
  wire        serial_out_en;
  wire        deep_sleep;
  wire        active_power;
  mem_req_s   mem_req;
  logic [7:0] mem_rdata;
  nv_bits_s   nv_init;
  nv_bits_s   nv_store;
  logic [7:0] mem [int];
  logic [7:0] st;
  int         failures = 0;
  int         checks_done = 0;
  int         n_se = 0;
  int         n_all = 0;
  int         n_wr = 0;
  int         cycles = 0;
  int         lim [0:7] = '{32'h100000, 32'h0F0000, 32'h0E0000, 32'h0C0000, 32'h080000, 32'h0, 32'h0, 32'h0};

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  serial_flash_protect_power_hold #(.PROGRAM_TIME_US(5), .SECTOR_ERASE_TIME_US(5), .ARRAY_ERASE_TIME_US(5),
    .STATUS_WRITE_TIME_US(5), .POWERUP_DELAY_US(20)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .serial_in(serial_in), .hold_n(hold_n), .wp_n(wp_n), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .mem_req(mem_req), .mem_rdata(mem_rdata), .nv_init(nv_init),
    .nv_store(nv_store), .deep_sleep(deep_sleep), .active_power(active_power));
  host_link_model host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .hold_n(hold_n),
    .serial_out(serial_out), .serial_out_en(serial_out_en));

  // array stand-in: bytes never written read as erased
  always @* mem_rdata = mem.exists(int'(mem_req.addr)) ? mem[int'(mem_req.addr)] : 8'hFF;
  always @(posedge ref_clk) begin
    cycles++;
    if (mem_req.wr === 1'b1) begin
      mem[int'(mem_req.addr)] = mem_req.wdata;
      n_wr++;
    end
    if (mem_req.erase_sector === 1'b1) n_se++;
    if (mem_req.erase_all === 1'b1) n_all++;
    if (cycles == 100000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int bits);
    host.tx_buf[0] = op;
    host.tx_buf[1] = a[23:16];
    host.tx_buf[2] = a[15:8];
    host.tx_buf[3] = a[7:0];
    host.frame(bits, 1'b0, -1);
  endtask : cmd
  // last byte of a long read, since the status view lags a few link edges
  task automatic rdsr(input int h);
    host.tx_buf[0] = STATUS_READ_CMD;
    host.frame(32, 1'b0, h);
    st = host.rx;
  endtask : rdsr
  task automatic wait_idle;
    int i;
    repeat (20) @(posedge ref_clk);
    for (i = 0; i < 3000 && active_power !== 1'b0; i++) @(posedge ref_clk);
    check("active_power", active_power, 1'b0);
  endtask : wait_idle

  task automatic t_reset;
    check("nv_store", nv_store, nv_init);
    check("deep_sleep", deep_sleep, 1'b0);
    rdsr(-1);
    check("status", st, 8'h04);
  endtask : t_reset
  task automatic t_powerup;
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(SECTOR_ERASE_CMD, 24'h0, 32);
    repeat (50) @(posedge ref_clk);
    check("early erase", n_se, 0);
    repeat (4000) @(posedge ref_clk);
    cmd(WRITE_DISABLE_CMD, 24'h0, 8);
  endtask : t_powerup
  task automatic t_erase;
    cmd(SECTOR_ERASE_CMD, 24'h010000, 32);
    repeat (50) @(posedge ref_clk);
    check("erase no latch", n_se, 0);
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(SECTOR_ERASE_CMD, 24'h010000, 32);
    rdsr(-1);
    check("busy wel", st, 8'h07);
    check("erase count", n_se, 1);
    check("active busy", active_power, 1'b1);
    wait_idle();
    rdsr(-1);
    check("after erase", st, 8'h04);
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(ARRAY_ERASE_CMD, 24'h0, 8);
    repeat (50) @(posedge ref_clk);
    check("array erase locked", n_all, 0);
    cmd(WRITE_DISABLE_CMD, 24'h0, 8);
  endtask : t_erase
  task automatic t_program;
    mem[32'h12FF] = 8'h0F;
    host.tx_buf[4] = 8'hA5;
    host.tx_buf[5] = 8'h3C;
    host.tx_buf[6] = 8'h81;
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(PAGE_PROGRAM_CMD, 24'h0012FE, 56);
    wait_idle();
    check("byte 12FE", mem[32'h12FE], 8'hA5);
    check("byte 12FF", mem[32'h12FF], 8'h0C);
    check("byte 1200", mem[32'h1200], 8'h81);
    check("writes", n_wr, 3);
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(PAGE_PROGRAM_CMD, 24'h000100, 41);
    rdsr(-1);
    check("odd bits", n_wr, 3);
    check("wel kept", st, 8'h06);
    cmd(WRITE_DISABLE_CMD, 24'h0, 8);
  endtask : t_program
  task automatic t_hold;
    host.en_in_hold = 1'b0;
    host.tx_buf[0] = WRITE_ENABLE_CMD;
    host.frame(8, 1'b1, 4);
    rdsr(20);
    check("paused count", st, 8'h06);
    check("en in pause", host.en_in_hold, 1'b0);
    cmd(WRITE_DISABLE_CMD, 24'h0, 8);
  endtask : t_hold
  task automatic t_protect;
    int c;
    int k;
    int a;
    int e;
    for (c = 0; c < 8; c++) begin
      cmd(WRITE_ENABLE_CMD, 24'h0, 8);
      cmd(STATUS_WRITE_CMD, {3'h0, c[2:0], 18'h0}, 16);
      wait_idle();
      check("bp", nv_store.bp, c);
      for (k = 0; k < 2; k++) begin
        a = (k == 0) ? ((lim[c] == 0) ? 0 : lim[c] - 1) : ((lim[c] > 32'hFFFFF) ? 32'hFFFFF : lim[c]);
        e = n_se + ((a < lim[c]) ? 1 : 0);
        cmd(WRITE_ENABLE_CMD, 24'h0, 8);
        cmd(SECTOR_ERASE_CMD, a[23:0], 32);
        wait_idle();
        check("region", n_se, e);
        cmd(WRITE_DISABLE_CMD, 24'h0, 8);
      end
    end
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(STATUS_WRITE_CMD, 24'h800000, 16);
    wait_idle();
    @(negedge ref_clk) wp_n = 1'b0;
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(STATUS_WRITE_CMD, 24'h1C0000, 16);
    wait_idle();
    check("locked status", nv_store, 4'h8);
    @(negedge ref_clk) wp_n = 1'b1;
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(STATUS_WRITE_CMD, 24'h0, 16);
    wait_idle();
    check("unlocked status", nv_store, 4'h0);
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(ARRAY_ERASE_CMD, 24'h0, 8);
    wait_idle();
    check("array erase", n_all, 1);
  endtask : t_protect
  task automatic t_sleep;
    int e;
    e = n_se;
    cmd(DEEP_SLEEP_CMD, 24'h0, 8);
    repeat (20) @(posedge ref_clk);
    check("asleep", deep_sleep, 1'b1);
    cmd(WRITE_ENABLE_CMD, 24'h0, 8);
    cmd(SECTOR_ERASE_CMD, 24'h020000, 32);
    repeat (50) @(posedge ref_clk);
    check("sleep erase", n_se, e);
    check("still asleep", deep_sleep, 1'b1);
    cmd(WAKE_AND_ID_CMD, 24'h0, 32);
    repeat (20) @(posedge ref_clk);
    check("awake", deep_sleep, 1'b0);
    rdsr(-1);
    check("sleep wel", st, 8'h00);
  endtask : t_sleep

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    nv_init = '{status_protect_bit: 1'b0, bp: 3'h1};
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    t_reset();
    t_powerup();
    t_erase();
    t_program();
    t_hold();
    t_protect();
    t_sleep();
    final_report();
  end
endmodule : serial_flash_protect_power_hold_bench
